// ===== pkg/lowvolt_reset_flag_defines.svh
// lowvolt_reset_flag_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and the core, 10 MHz system clock
`ifndef LOWVOLT_RESET_FLAG_DEFINES_SVH
`define LOWVOLT_RESET_FLAG_DEFINES_SVH

`define LOWVOLT_RESET_FLAG_ADDR_W          8
`define LOWVOLT_RESET_FLAG_OFF_THRESH      8'h00
`define LOWVOLT_RESET_FLAG_OFF_FILTER      8'h04
`define LOWVOLT_RESET_FLAG_OFF_FLAGS       8'h08
`define LOWVOLT_RESET_FLAG_OFF_WDT_KEY     8'h0C
`define LOWVOLT_RESET_FLAG_OFF_FLASH_CTL1  8'h10
`define LOWVOLT_RESET_FLAG_OFF_TO_PD       8'h14
`define LOWVOLT_RESET_FLAG_OFF_IRQ_STAT    8'h18
`define LOWVOLT_RESET_FLAG_OFF_IRQ_MASK    8'h1C

`define LOWVOLT_RESET_FLAG_CODE_1V70       8'b0110_0110
`define LOWVOLT_RESET_FLAG_CODE_1V90       8'b0101_0101
`define LOWVOLT_RESET_FLAG_CODE_2V55       8'b0011_0011
`define LOWVOLT_RESET_FLAG_CODE_3V15       8'b1001_1001
`define LOWVOLT_RESET_FLAG_CODE_3V80       8'b1010_1010
`define LOWVOLT_RESET_FLAG_CODE_OFF        8'b1111_0000
`define LOWVOLT_RESET_FLAG_THRESH_POR      8'h99
`define LOWVOLT_RESET_FLAG_FILTER_POR      2'b01

`define LOWVOLT_RESET_FLAG_WKEY_DISABLE    5'b1_0101
`define LOWVOLT_RESET_FLAG_WKEY_ENABLE     5'b0_1010
`define LOWVOLT_RESET_FLAG_WKEY_POR        5'b0_1010
`define LOWVOLT_RESET_FLAG_FLASH_KEY       8'h55

`define LOWVOLT_RESET_FLAG_BIT_LOWVOLT_RESET_FLAG        2
`define LOWVOLT_RESET_FLAG_BIT_LRF         1
`define LOWVOLT_RESET_FLAG_BIT_WRF         0
`define LOWVOLT_RESET_FLAG_BIT_TO          1
`define LOWVOLT_RESET_FLAG_BIT_PDF         0

// irq status bit positions
`define LOWVOLT_RESET_FLAG_IRQ_LOWVOLT     0
`define LOWVOLT_RESET_FLAG_IRQ_CODE        1
`define LOWVOLT_RESET_FLAG_IRQ_WKEY        2
`define LOWVOLT_RESET_FLAG_IRQ_FLASH       3
`define LOWVOLT_RESET_FLAG_IRQ_WDT         4
`define LOWVOLT_RESET_FLAG_IRQ_W           5

// filter lengths in slow oscillator periods
`define LOWVOLT_RESET_FLAG_FILT_N0         8
`define LOWVOLT_RESET_FLAG_FILT_N1         32
`define LOWVOLT_RESET_FLAG_FILT_N2         64
`define LOWVOLT_RESET_FLAG_FILT_N3         128

`define LOWVOLT_RESET_FLAG_CLK_NS          100
`define LOWVOLT_RESET_FLAG_SRESET_NS       1600
`define LOWVOLT_RESET_FLAG_SRESET_CYC      ((`LOWVOLT_RESET_FLAG_SRESET_NS + `LOWVOLT_RESET_FLAG_CLK_NS - 1) / `LOWVOLT_RESET_FLAG_CLK_NS)
`define LOWVOLT_RESET_FLAG_RST_HOLD_CYC    4

`endif

// ===== pkg/lowvolt_reset_flag_pkg.sv
// lowvolt_reset_flag_pkg: types shared by the reset and flag block
// assumes: lowvolt_reset_flag_defines.svh on the include path
`include "lowvolt_reset_flag_defines.svh"
package lowvolt_reset_flag_pkg;

  typedef struct packed {
    logic [`LOWVOLT_RESET_FLAG_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic                    wr;
    logic                    rd;
  } lowvolt_reset_flag_bus_req_t;

  typedef enum logic [2:0] {
    LOWVOLT_RESET_FLAG_LVL_1V70 = 3'h0,
    LOWVOLT_RESET_FLAG_LVL_1V90 = 3'h1,
    LOWVOLT_RESET_FLAG_LVL_2V55 = 3'h2,
    LOWVOLT_RESET_FLAG_LVL_3V15 = 3'h3,
    LOWVOLT_RESET_FLAG_LVL_3V80 = 3'h4,
    LOWVOLT_RESET_FLAG_LVL_OFF  = 3'h7
  } lowvolt_reset_flag_level_t;

  typedef enum logic [1:0] {
    LOWVOLT_RESET_FLAG_RS_IDLE = 2'b01,
    LOWVOLT_RESET_FLAG_RS_HOLD = 2'b10
  } lowvolt_reset_flag_rst_state_t;

endpackage

// ===== core/lowvolt_reset_flag_top.sv
// lowvolt_reset_flag_top: low-voltage reset control, reset-cause flags and chip reset merge
// assumes: one 10 MHz clock; slow oscillator and comparator arrive as async pins;
// sleep/idle state, watchdog time-out pulse come from logic on clk
// limitation: slow_osc_pin must stay several clk periods in each level, or ticks are lost
//
// Contract
// [R1] threshold code selects level or disable
// [R2] undefined code: full reset, field restored
// [R3] undefined code reset waits soft delay
// [R4] filtered low voltage resets, field kept
// [R5] filter field picks 8/32/64/128 periods
// [R6] filter register upper six bits read zero
// [R7] flag register upper five bits read zero
// [R8] low-voltage flag set by hardware, software clears
// [R9] code flag set on undefined code
// [R10] flash control key 55h resets chip
// [R11] normal watchdog time-out resets, sets timeout
// [R12] sleep time-out clears pc/sp, sets both flags
// [R13] power-on clears flags, low-voltage keeps them
// [R14] power-on reset initialises core state
// [R15] watchdog-key flag set on bad key
// [R16] bad watchdog key resets after delay
// [R17] low-voltage reset suspended in sleep/idle
// [R18] filter counts low periods, restarts on recovery
// [R19] all requests merge into one reset
`timescale 1ns/1ps
`include "lowvolt_reset_flag_defines.svh"

module lowvolt_reset_flag_top
  import lowvolt_reset_flag_pkg::*;
#(
  parameter int SRESET_CYC = `LOWVOLT_RESET_FLAG_SRESET_CYC,
  parameter int HOLD_CYC   = `LOWVOLT_RESET_FLAG_RST_HOLD_CYC
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire lowvolt_reset_flag_bus_req_t bus_req,
  output logic [7:0]         rdata_ff,
  input  wire logic          slow_osc_pin,
  input  wire logic          supply_low_pin,
  input  wire logic          sleep_idle,
  input  wire logic          wdt_timeout,
  output lowvolt_reset_flag_level_t        lvr_level_ff,
  output logic               wdt_enable_ff,
  output logic               chip_rst_ff,
  output logic               pc_sp_clr_ff,
  output logic               timeout_flag_ff,
  output logic               powerdown_flag_ff,
  output logic               irq_ff
);

  function automatic logic code_defined(input logic [7:0] c);
    code_defined = (c == `LOWVOLT_RESET_FLAG_CODE_1V70) || (c == `LOWVOLT_RESET_FLAG_CODE_1V90) || (c == `LOWVOLT_RESET_FLAG_CODE_2V55) ||
                   (c == `LOWVOLT_RESET_FLAG_CODE_3V15) || (c == `LOWVOLT_RESET_FLAG_CODE_3V80) || (c == `LOWVOLT_RESET_FLAG_CODE_OFF);
  endfunction

  function automatic logic hit(input logic [`LOWVOLT_RESET_FLAG_ADDR_W-1:0] a, input logic [`LOWVOLT_RESET_FLAG_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic delay_over(input logic [15:0] cnt);
    delay_over = (cnt == 16'(SRESET_CYC - 1));
  endfunction

  // a set in the same cycle as a clearing write wins, so no event is lost
  function automatic logic sticky_next(input logic set, input logic cur, input logic wr_en, input logic wr_bit);
    sticky_next = set || (cur && !(wr_en && !wr_bit));
  endfunction

  logic [7:0]            thresh_ff;
  logic [1:0]            filter_ff;
  logic [2:0]            flags_ff;
  logic [4:0]            wkey_ff;
  logic [`LOWVOLT_RESET_FLAG_IRQ_W-1:0] irq_stat_ff;
  logic [`LOWVOLT_RESET_FLAG_IRQ_W-1:0] irq_mask_ff;
  logic [1:0]            osc_sync_ff;
  logic                  osc_prev_ff;
  logic [1:0]            low_sync_ff;
  logic [7:0]            filt_cnt_ff;
  logic                  code_pend_ff;
  logic                  wkey_pend_ff;
  logic [15:0]           code_cnt_ff;
  logic [15:0]           wkey_cnt_ff;
  logic [7:0]            hold_cnt_ff;
  lowvolt_reset_flag_rst_state_t       rst_state_ff;

  logic                  wr_thresh;
  logic                  wr_filter;
  logic                  wr_flags;
  logic                  wr_wkey;
  logic                  wr_flash;
  logic                  wr_istat;
  logic                  wr_imask;
  logic                  osc_tick;
  logic                  lvr_armed;
  logic [7:0]            filt_len;
  logic                  lowvolt_trip;
  logic                  code_bad;
  logic                  wkey_bad;
  logic                  code_done;
  logic                  wkey_done;
  logic                  dly_done;
  logic                  full_rst;
  logic                  flash_trip;
  logic                  wdt_norm;
  logic                  wdt_sleep;
  logic                  rst_req;
  logic [`LOWVOLT_RESET_FLAG_IRQ_W-1:0] irq_ev;

  assign wr_thresh = bus_req.wr && hit(bus_req.addr, `LOWVOLT_RESET_FLAG_OFF_THRESH);
  assign wr_filter = bus_req.wr && hit(bus_req.addr, `LOWVOLT_RESET_FLAG_OFF_FILTER);
  assign wr_flags  = bus_req.wr && hit(bus_req.addr, `LOWVOLT_RESET_FLAG_OFF_FLAGS);
  assign wr_wkey   = bus_req.wr && hit(bus_req.addr, `LOWVOLT_RESET_FLAG_OFF_WDT_KEY);
  assign wr_flash  = bus_req.wr && hit(bus_req.addr, `LOWVOLT_RESET_FLAG_OFF_FLASH_CTL1);
  assign wr_istat  = bus_req.wr && hit(bus_req.addr, `LOWVOLT_RESET_FLAG_OFF_IRQ_STAT);
  assign wr_imask  = bus_req.wr && hit(bus_req.addr, `LOWVOLT_RESET_FLAG_OFF_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and slow oscillator period tick

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_sync_ff <= 2'b00;
      osc_prev_ff <= 1'b0;
      low_sync_ff <= 2'b00;
    end else begin
      osc_sync_ff <= {osc_sync_ff[0], slow_osc_pin};
      osc_prev_ff <= osc_sync_ff[1];
      low_sync_ff <= {low_sync_ff[0], supply_low_pin};
    end
  end

  assign osc_tick = osc_sync_ff[1] && !osc_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // level decode and low-voltage filter

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvr_level_ff <= LOWVOLT_RESET_FLAG_LVL_3V15;
    end else begin
      unique case (thresh_ff) // R1
        `LOWVOLT_RESET_FLAG_CODE_1V70: lvr_level_ff <= LOWVOLT_RESET_FLAG_LVL_1V70;
        `LOWVOLT_RESET_FLAG_CODE_1V90: lvr_level_ff <= LOWVOLT_RESET_FLAG_LVL_1V90;
        `LOWVOLT_RESET_FLAG_CODE_2V55: lvr_level_ff <= LOWVOLT_RESET_FLAG_LVL_2V55;
        `LOWVOLT_RESET_FLAG_CODE_3V15: lvr_level_ff <= LOWVOLT_RESET_FLAG_LVL_3V15;
        `LOWVOLT_RESET_FLAG_CODE_3V80: lvr_level_ff <= LOWVOLT_RESET_FLAG_LVL_3V80;
        default:         lvr_level_ff <= LOWVOLT_RESET_FLAG_LVL_OFF;
      endcase
    end
  end

  // undefined codes arm nothing here; their own reset path takes over
  assign lvr_armed = code_defined(thresh_ff) && (thresh_ff != `LOWVOLT_RESET_FLAG_CODE_OFF) && !sleep_idle; // R17

  always_comb begin
    unique case (filter_ff) // R5
      2'b00:   filt_len = 8'(`LOWVOLT_RESET_FLAG_FILT_N0);
      2'b01:   filt_len = 8'(`LOWVOLT_RESET_FLAG_FILT_N1);
      2'b10:   filt_len = 8'(`LOWVOLT_RESET_FLAG_FILT_N2);
      default: filt_len = 8'(`LOWVOLT_RESET_FLAG_FILT_N3);
    endcase
  end

  // the first tick lands anywhere in a period, hence the one-period spread
  assign lowvolt_trip = lvr_armed && low_sync_ff[1] && osc_tick && (filt_cnt_ff == filt_len - 8'd1); // R4

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt_cnt_ff <= 8'h00;
    end else if (!lvr_armed || !low_sync_ff[1] || lowvolt_trip) begin
      filt_cnt_ff <= 8'h00; // R18
    end else if (osc_tick) begin
      filt_cnt_ff <= filt_cnt_ff + 8'd1; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft reset delay for bad threshold code and bad watchdog key
  // one timer per source: the first delay to end resets the chip and voids a fault still pending on the other timer

  assign code_bad  = !code_defined(thresh_ff);
  assign wkey_bad  = (wkey_ff != `LOWVOLT_RESET_FLAG_WKEY_ENABLE) && (wkey_ff != `LOWVOLT_RESET_FLAG_WKEY_DISABLE);
  assign code_done = code_pend_ff && delay_over(code_cnt_ff);
  assign wkey_done = wkey_pend_ff && delay_over(wkey_cnt_ff);
  assign dly_done  = code_done || wkey_done;

  // any full reset other than low voltage reloads both fields, so a fault still pending is void
  always_ff @(posedge clk) begin
    if (sys_rst || full_rst) begin
      code_pend_ff <= 1'b0;
      code_cnt_ff  <= 16'h0000;
    end else begin
      if (code_bad) begin
        code_pend_ff <= 1'b1; // R3
      end
      if (code_pend_ff) begin
        code_cnt_ff <= code_cnt_ff + 16'd1; // R3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || full_rst) begin
      wkey_pend_ff <= 1'b0;
      wkey_cnt_ff  <= 16'h0000;
    end else begin
      if (wkey_bad) begin
        wkey_pend_ff <= 1'b1; // R16
      end
      if (wkey_pend_ff) begin
        wkey_cnt_ff <= wkey_cnt_ff + 16'd1; // R16
      end
    end
  end

  assign flash_trip = wr_flash && (bus_req.wdata == `LOWVOLT_RESET_FLAG_FLASH_KEY); // R10
  assign wdt_norm   = wdt_timeout && !sleep_idle;
  assign wdt_sleep  = wdt_timeout && sleep_idle;
  assign rst_req    = lowvolt_trip || dly_done || flash_trip || wdt_norm; // R19
  // full resets other than the filtered low-voltage one
  assign full_rst   = dly_done || flash_trip || wdt_norm;

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thresh_ff <= `LOWVOLT_RESET_FLAG_THRESH_POR;
      wkey_ff   <= `LOWVOLT_RESET_FLAG_WKEY_POR;
    end else if (full_rst) begin
      // full resets other than low voltage reload both fields
      thresh_ff <= `LOWVOLT_RESET_FLAG_THRESH_POR; // R2
      wkey_ff   <= `LOWVOLT_RESET_FLAG_WKEY_POR;
    end else if (!lowvolt_trip) begin // R4
      if (wr_thresh) begin
        thresh_ff <= bus_req.wdata;
      end
      if (wr_wkey) begin
        wkey_ff <= bus_req.wdata[7:3];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filter_ff <= `LOWVOLT_RESET_FLAG_FILTER_POR;
    end else if (wr_filter) begin
      filter_ff <= bus_req.wdata[1:0];
    end
  end

  // writing zero clears a flag; a same-cycle set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_ff <= 3'b000;
    end else begin
      flags_ff[`LOWVOLT_RESET_FLAG_BIT_LOWVOLT_RESET_FLAG] <= sticky_next(lowvolt_trip, flags_ff[`LOWVOLT_RESET_FLAG_BIT_LOWVOLT_RESET_FLAG], wr_flags,
                                              bus_req.wdata[`LOWVOLT_RESET_FLAG_BIT_LOWVOLT_RESET_FLAG]); // R8
      flags_ff[`LOWVOLT_RESET_FLAG_BIT_LRF]  <= sticky_next(code_bad, flags_ff[`LOWVOLT_RESET_FLAG_BIT_LRF], wr_flags,
                                              bus_req.wdata[`LOWVOLT_RESET_FLAG_BIT_LRF]); // R9
      flags_ff[`LOWVOLT_RESET_FLAG_BIT_WRF]  <= sticky_next(wkey_bad, flags_ff[`LOWVOLT_RESET_FLAG_BIT_WRF], wr_flags,
                                              bus_req.wdata[`LOWVOLT_RESET_FLAG_BIT_WRF]); // R15
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timeout_flag_ff   <= 1'b0; // R13
      powerdown_flag_ff <= 1'b0; // R13
    end else if (wdt_sleep) begin
      timeout_flag_ff   <= 1'b1; // R12
      powerdown_flag_ff <= 1'b1; // R12
    end else if (wdt_norm) begin
      timeout_flag_ff   <= 1'b1; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_enable_ff <= 1'b1;
    end else begin
      wdt_enable_ff <= (wkey_ff != `LOWVOLT_RESET_FLAG_WKEY_DISABLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  assign irq_ev = {wdt_timeout, flash_trip, wkey_done, code_done, lowvolt_trip};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_ff <= '0;
    end else if (wr_istat) begin
      irq_stat_ff <= irq_ev | (irq_stat_ff & ~bus_req.wdata[`LOWVOLT_RESET_FLAG_IRQ_W-1:0]);
    end else begin
      irq_stat_ff <= irq_ev | irq_stat_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask_ff <= '0;
    end else if (wr_imask) begin
      irq_mask_ff <= bus_req.wdata[`LOWVOLT_RESET_FLAG_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe

  always_ff @(posedge clk) begin
    if (sys_rst || !bus_req.rd) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (bus_req.addr)
        `LOWVOLT_RESET_FLAG_OFF_THRESH:     rdata_ff <= thresh_ff;
        `LOWVOLT_RESET_FLAG_OFF_FILTER:     rdata_ff <= {6'b00_0000, filter_ff}; // R6
        `LOWVOLT_RESET_FLAG_OFF_FLAGS:      rdata_ff <= {5'b0_0000, flags_ff}; // R7
        `LOWVOLT_RESET_FLAG_OFF_WDT_KEY:    rdata_ff <= {wkey_ff, 3'b000};
        `LOWVOLT_RESET_FLAG_OFF_FLASH_CTL1: rdata_ff <= 8'h00; // key register is write-only
        `LOWVOLT_RESET_FLAG_OFF_TO_PD:      rdata_ff <= {6'b00_0000, timeout_flag_ff, powerdown_flag_ff};
        `LOWVOLT_RESET_FLAG_OFF_IRQ_STAT:   rdata_ff <= {3'b000, irq_stat_ff};
        `LOWVOLT_RESET_FLAG_OFF_IRQ_MASK:   rdata_ff <= {3'b000, irq_mask_ff};
        default:              rdata_ff <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // merged chip reset: held a fixed number of cycles, released on clk
  // a request during the hold restarts the count, so the release is always clean

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_state_ff <= LOWVOLT_RESET_FLAG_RS_HOLD;
      hold_cnt_ff  <= 8'h00;
      chip_rst_ff  <= 1'b1; // R14
    end else begin
      unique case (rst_state_ff)
        LOWVOLT_RESET_FLAG_RS_IDLE: begin
          chip_rst_ff <= rst_req; // R19
          hold_cnt_ff <= 8'h00;
          if (rst_req) begin
            rst_state_ff <= LOWVOLT_RESET_FLAG_RS_HOLD;
          end
        end
        LOWVOLT_RESET_FLAG_RS_HOLD: begin
          hold_cnt_ff <= rst_req ? 8'h00 : hold_cnt_ff + 8'd1;
          if (!rst_req && hold_cnt_ff == 8'(HOLD_CYC - 1)) begin
            chip_rst_ff  <= 1'b0;
            rst_state_ff <= LOWVOLT_RESET_FLAG_RS_IDLE;
          end else begin
            chip_rst_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // sleep time-out touches only pc/sp, the two flags and the WDT irq status bit, never the chip reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_sp_clr_ff <= 1'b0;
    end else begin
      pc_sp_clr_ff <= wdt_sleep; // R12
    end
  end

endmodule // lowvolt_reset_flag_top

// ===== bench/lowvolt_reset_flag_assertions.sv
// lowvolt_reset_flag_assertions.sv: port-level checks of the reset and flag block
// assumes: bound into every lowvolt_reset_flag_top, sync active-high sys_rst
`timescale 1ns/1ps
`include "lowvolt_reset_flag_defines.svh"

module lowvolt_reset_flag_chk
  import lowvolt_reset_flag_pkg::*;
#(
  parameter int SRESET_CYC = 16,
  parameter int HOLD_CYC   = 4
) (
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire lowvolt_reset_flag_bus_req_t bus_req,
  input wire logic [7:0]    rdata_ff,
  input wire logic          slow_osc_pin,
  input wire logic          supply_low_pin,
  input wire logic          sleep_idle,
  input wire logic          wdt_timeout,
  input wire lowvolt_reset_flag_level_t   lvr_level_ff,
  input wire logic          wdt_enable_ff,
  input wire logic          chip_rst_ff,
  input wire logic          pc_sp_clr_ff,
  input wire logic          timeout_flag_ff,
  input wire logic          powerdown_flag_ff,
  input wire logic          irq_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  wire wr_thr  = bus_req.wr && bus_req.addr == `LOWVOLT_RESET_FLAG_OFF_THRESH;
  wire wr_fl   = bus_req.wr && bus_req.addr == `LOWVOLT_RESET_FLAG_OFF_FLASH_CTL1;
  wire wd_slp  = wdt_timeout && sleep_idle;
  wire code_ok = bus_req.wdata inside {`LOWVOLT_RESET_FLAG_CODE_1V70, `LOWVOLT_RESET_FLAG_CODE_1V90, `LOWVOLT_RESET_FLAG_CODE_2V55,
                                       `LOWVOLT_RESET_FLAG_CODE_3V15, `LOWVOLT_RESET_FLAG_CODE_3V80, `LOWVOLT_RESET_FLAG_CODE_OFF};
  // a write dropped by a coinciding reset still shows as chip reset
  wire wr_170  = wr_thr && bus_req.wdata == `LOWVOLT_RESET_FLAG_CODE_1V70 && !chip_rst_ff;
  // consecutive high cycles of the chip reset, saturating
  logic [7:0] rst_hi_cnt_ff;
  always_ff @(posedge clk) begin
    if (sys_rst || !chip_rst_ff) begin
      rst_hi_cnt_ff <= 8'h00;
    end else if (rst_hi_cnt_ff != 8'hFF) begin
      rst_hi_cnt_ff <= rst_hi_cnt_ff + 8'd1;
    end
  end

  a_flash_key_rst: assert property (wr_fl && bus_req.wdata == `LOWVOLT_RESET_FLAG_FLASH_KEY |=> chip_rst_ff)
    else $error("flash key write gave no reset");
  a_bad_code_rst: assert property (wr_thr && !code_ok && !chip_rst_ff |-> ##[2:40] chip_rst_ff)
    else $error("undefined code gave no delayed reset");
  a_code_level: assert property (wr_170 |=> ##1 (lvr_level_ff == LOWVOLT_RESET_FLAG_LVL_1V70 || chip_rst_ff))
    else $error("level does not follow code");
  a_wdt_normal: assert property (wdt_timeout && !sleep_idle |=> chip_rst_ff && timeout_flag_ff)
    else $error("normal time-out without reset or flag");
  a_wdt_sleep: assert property (wd_slp |=> pc_sp_clr_ff && timeout_flag_ff && powerdown_flag_ff)
    else $error("sleep time-out effects missing");
  a_pcsp_cause: assert property (pc_sp_clr_ff |-> $past(wd_slp))
    else $error("pc/sp clear without sleep time-out");
  a_filt_upper: assert property (bus_req.rd && bus_req.addr == `LOWVOLT_RESET_FLAG_OFF_FILTER |=> rdata_ff[7:2] == 6'h0)
    else $error("filter upper bits not zero");
  a_flag_upper: assert property (bus_req.rd && bus_req.addr == `LOWVOLT_RESET_FLAG_OFF_FLAGS |=> rdata_ff[7:3] == 5'h0)
    else $error("flag upper bits not zero");
  a_rst_hold: assert property ($fell(chip_rst_ff) |-> rst_hi_cnt_ff >= 8'(HOLD_CYC))
    else $error("chip reset too short");
  a_flag_sticky: assert property (!$fell(timeout_flag_ff) && !$fell(powerdown_flag_ff))
    else $error("timeout or power-down flag dropped");
endmodule // lowvolt_reset_flag_chk

bind lowvolt_reset_flag_top lowvolt_reset_flag_chk #(.SRESET_CYC(SRESET_CYC), .HOLD_CYC(HOLD_CYC)) u_lowvolt_reset_flag_chk (
  .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata_ff(rdata_ff),
  .slow_osc_pin(slow_osc_pin), .supply_low_pin(supply_low_pin), .sleep_idle(sleep_idle),
  .wdt_timeout(wdt_timeout), .lvr_level_ff(lvr_level_ff), .wdt_enable_ff(wdt_enable_ff),
  .chip_rst_ff(chip_rst_ff), .pc_sp_clr_ff(pc_sp_clr_ff), .timeout_flag_ff(timeout_flag_ff),
  .powerdown_flag_ff(powerdown_flag_ff), .irq_ff(irq_ff)
);

// ===== bench/tb_top.sv
// tb_top.sv: self-checking bench for lowvolt_reset_flag_top with a small register model
// assumes: lowvolt_reset_flag_pkg and the checker compiled first, defines on include path
`timescale 1ns/1ps
`include "lowvolt_reset_flag_defines.svh"
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end

module tb_top
  import lowvolt_reset_flag_pkg::*;
;
  localparam int S = 4;
  logic          clk = 1'b0, sys_rst = 1'b1, slow_osc_pin = 1'b0;
  logic          supply_low_pin = 1'b0, sleep_idle = 1'b0, wdt_timeout = 1'b0;
  lowvolt_reset_flag_bus_req_t bus_req = '0;
  logic [7:0]    rdata_ff, rv;
  logic [7:0]    codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
  lowvolt_reset_flag_level_t   lvls [6] = '{LOWVOLT_RESET_FLAG_LVL_1V70, LOWVOLT_RESET_FLAG_LVL_1V90, LOWVOLT_RESET_FLAG_LVL_2V55,
                              LOWVOLT_RESET_FLAG_LVL_3V15, LOWVOLT_RESET_FLAG_LVL_3V80, LOWVOLT_RESET_FLAG_LVL_OFF};
  lowvolt_reset_flag_level_t   lvr_level_ff;
  logic          wdt_enable_ff, chip_rst_ff, pc_sp_clr_ff, timeout_flag_ff, powerdown_flag_ff, irq_ff;
  int            n_mismatch = 0, tests_run = 0, seed = 56279, thr = 'h99, n;

  lowvolt_reset_flag_top #(.SRESET_CYC(S), .HOLD_CYC(1)) DUT (
    .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata_ff(rdata_ff),
    .slow_osc_pin(slow_osc_pin), .supply_low_pin(supply_low_pin), .sleep_idle(sleep_idle),
    .wdt_timeout(wdt_timeout), .lvr_level_ff(lvr_level_ff), .wdt_enable_ff(wdt_enable_ff),
    .chip_rst_ff(chip_rst_ff), .pc_sp_clr_ff(pc_sp_clr_ff), .timeout_flag_ff(timeout_flag_ff),
    .powerdown_flag_ff(powerdown_flag_ff), .irq_ff(irq_ff));

  initial forever #50 clk = ~clk;
  // slow tick every 16 clocks, far below clk so the 2-ff sync sees each edge
  always begin
    repeat (8) @(posedge clk);
    slow_osc_pin <= ~slow_osc_pin;
  end
  // whole run is about 650 cycles
  initial begin
    #2_000_000;
    n_mismatch++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input int e);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    @(negedge clk) rv = rdata_ff;
    `CHK($sformatf("reg %h", a), e, rv)
  endtask
  task automatic wdt;
    @(posedge clk) wdt_timeout <= 1'b1;
    @(posedge clk) wdt_timeout <= 1'b0;
  endtask
  task automatic cnt_rst;
    int k = 0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (chip_rst_ff !== 1'b1 && n < 400);
    while (chip_rst_ff !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK("por_rst", 1'b1, chip_rst_ff)
    repeat (3) @(negedge clk);
    rchk(8'h00, thr);
    rchk(8'h04, 'h01);
    rchk(8'h08, 0);
    rchk(8'h14, 0);
    rchk(8'h30, 0);
    `CHK("wdt_en", 1'b1, wdt_enable_ff)
    for (int i = 0; i < 4; i++) begin
      rv = 8'($random(seed));
      wr(8'h04, rv);
      rchk(8'h04, rv & 3);
      wr(8'h08, 8'($random(seed)));
      rchk(8'h08, 0);
    end
    for (int i = 0; i < 6; i++) begin
      thr = codes[i];
      wr(8'h00, codes[i]);
      rchk(8'h00, thr);
      `CHK("level", lvls[i], lvr_level_ff)
    end
    wr(8'h1C, 8'h1F);
    wr(8'h10, 8'h55);
    cnt_rst;
    `CHK("flash_rst", 1, n)
    thr = 'h99;
    rchk(8'h00, thr);
    `CHK("irq", 1'b1, irq_ff)
    rchk(8'h18, 'h08);
    wr(8'h18, 8'h08);
    rchk(8'h18, 0);
    `CHK("irq", 1'b0, irq_ff)
    do rv = 8'($random(seed)); while (rv inside {codes});
    wr(8'h00, rv);
    cnt_rst;
    `CHK("code_rst", S + 2, n)
    rchk(8'h00, thr);
    rchk(8'h08, 'h02);
    wr(8'h08, 8'h00);
    rchk(8'h08, 0);
    wr(8'h0C, 8'h00);
    cnt_rst;
    `CHK("key_rst", S + 2, n)
    rchk(8'h08, 'h01);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'hA8);
    repeat (2) @(negedge clk);
    `CHK("wdt_en", 1'b0, wdt_enable_ff)
    wr(8'h0C, 8'h50);
    wdt;
    cnt_rst;
    `CHK("wdt_rst", 1, n)
    rchk(8'h14, 'h02);
    @(posedge clk) sleep_idle <= 1'b1;
    wdt;
    @(negedge clk);
    `CHK("pc_sp", 1'b1, pc_sp_clr_ff)
    `CHK("no_rst", 1'b0, chip_rst_ff)
    rchk(8'h14, 'h03);
    @(posedge clk) sleep_idle <= 1'b0;
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h66);
    // six ticks low then recovery: a count that did not restart would trip early
    @(posedge clk) supply_low_pin <= 1'b1;
    repeat (96) @(posedge clk);
    supply_low_pin <= 1'b0;
    repeat (20) @(posedge clk);
    supply_low_pin <= 1'b1;
    cnt_rst;
    `CHK("lv_time", 1'b1, n >= 100 && n <= 150)
    @(posedge clk) supply_low_pin <= 1'b0;
    rchk(8'h08, 'h04);
    rchk(8'h00, 'h66);
    rchk(8'h14, 'h03);
    wr(8'h08, 8'h00);
    rchk(8'h08, 0);
    @(posedge clk) sleep_idle <= 1'b1;
    supply_low_pin <= 1'b1;
    repeat (200) @(posedge clk);
    @(negedge clk);
    `CHK("lv_sleep", 1'b0, chip_rst_ff)
    rchk(8'h08, 0);
    @(posedge clk) supply_low_pin <= 1'b0;
    sleep_idle <= 1'b0;
    // power-on reset in mid-run must clear the flags left by the sleep time-out
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK("por_rst", 1'b1, chip_rst_ff)
    rchk(8'h14, 0);
    rchk(8'h00, 'h99);
    wrap_up;
  end
endmodule // tb_top
